// ### rtl/qds_serial_in.sv
`timescale 1ns/1ps
`include "qds_regs.svh"

module qds_serial_in (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        frame_select_n,
	input  wire logic        serial_clock,
	input  wire logic        serial_data_in,
	input  wire logic        enable_n,
	input  wire logic        addr_pin_0,
	input  wire logic        addr_pin_1,
	input  wire logic        load_all_strobe,
	output logic [15:0]      ch0_value,
	output logic [15:0]      ch1_value,
	output logic [15:0]      ch2_value,
	output logic [15:0]      ch3_value,
	output logic             word_applied,
	output logic             frame_aborted
);

	localparam int NP = `QDS_NPINS;
	localparam int WB = `QDS_WORD_BITS;
	localparam int DB = `QDS_DATA_BITS;

	function automatic qds_pkg::qds_mode_t mode_of(input logic [WB-1:0] w);
		mode_of = w[`QDS_MODE_HI:`QDS_MODE_LO];
	endfunction

	function automatic qds_pkg::qds_chan_t chan_of(input logic [WB-1:0] w);
		chan_of = w[`QDS_CHAN_HI:`QDS_CHAN_LO];
	endfunction

	// Pin synchronisers: three stages, a change counts when 2 and 3 agree
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] meta_r;
	logic [NP-1:0] sync2_r;
	logic [NP-1:0] sync3_r;
	logic [NP-1:0] pin_r;
	logic [NP-1:0] pin_d_r;
	logic [NP-1:0] pin_nxt;

	assign pin_raw = {addr_pin_1, addr_pin_0, load_all_strobe, enable_n,
	                  serial_data_in, serial_clock, frame_select_n};
	assign pin_nxt = (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r  <= `QDS_PIN_RST;
			sync2_r <= `QDS_PIN_RST;
			sync3_r <= `QDS_PIN_RST;
			pin_r   <= `QDS_PIN_RST;
			pin_d_r <= `QDS_PIN_RST;
		end else begin
			meta_r  <= pin_raw;
			sync2_r <= meta_r;
			sync3_r <= sync2_r;
			pin_r   <= pin_nxt;
			pin_d_r <= pin_r;
		end
	end

	wire       sync_fall = pin_d_r[`QDS_PIN_SYNC] & ~pin_r[`QDS_PIN_SYNC];
	wire       sync_rise = ~pin_d_r[`QDS_PIN_SYNC] & pin_r[`QDS_PIN_SYNC];
	wire       sclk_fall = pin_d_r[`QDS_PIN_SCLK] & ~pin_r[`QDS_PIN_SCLK];
	wire       load_rise = ~pin_d_r[`QDS_PIN_LOAD] & pin_r[`QDS_PIN_LOAD];
	wire       port_off  = pin_r[`QDS_PIN_EN];
	wire       din_bit   = pin_r[`QDS_PIN_DIN];
	wire [1:0] dev_addr  = {pin_r[`QDS_PIN_A1], pin_r[`QDS_PIN_A0]};

	// Frame engine
	qds_pkg::qds_frame_t state_r;
	qds_pkg::qds_frame_t state_nxt;
	logic [`QDS_CNT_BITS-1:0] cnt_r;
	logic [`QDS_CNT_BITS-1:0] cnt_nxt;
	logic [WB-1:0]            shreg_r;
	logic [WB-1:0]            shreg_nxt;
	logic [WB-1:0]            word_r;
	logic                     pend_r;
	logic                     abort_r;

	wire            start     = sync_fall & ~port_off;
	wire            abort     = (state_r == qds_pkg::QDS_SHIFT) &
	                            (sync_rise | port_off);
	wire            take_bit  = (state_r == qds_pkg::QDS_SHIFT) &
	                            ~abort & sclk_fall;
	wire [WB-1:0]   lock_word = {shreg_r[WB-2:0], din_bit};
	wire            lock      = take_bit & (cnt_r == `QDS_LAST_BIT);
	wire            addr_ok   = (lock_word[`QDS_ADDR_HI:`QDS_ADDR_LO] ==
	                             dev_addr);
	wire            push_ok;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		shreg_nxt = shreg_r;
		unique case (state_r)
			qds_pkg::QDS_IDLE, qds_pkg::QDS_LOCK: begin
				// Locked contents hold until a fresh falling frame select
				if (start) begin
					state_nxt = qds_pkg::QDS_SHIFT;
					cnt_nxt   = `QDS_CNT_RST;
				end
			end
			qds_pkg::QDS_SHIFT: begin
				if (abort) begin
					state_nxt = qds_pkg::QDS_IDLE;
					cnt_nxt   = `QDS_CNT_RST;
				end else if (take_bit) begin
					shreg_nxt = lock_word;
					cnt_nxt   = cnt_r + 1'b1;
					if (lock) begin
						state_nxt = qds_pkg::QDS_LOCK;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= qds_pkg::QDS_IDLE;
			cnt_r   <= `QDS_CNT_RST;
			shreg_r <= `QDS_WORD_RST;
			abort_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			shreg_r <= shreg_nxt;
			abort_r <= abort;
		end
	end

	// Hold the locked word until the buffer takes it; a new lock wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			word_r <= `QDS_WORD_RST;
			pend_r <= 1'b0;
		end else if (lock & addr_ok) begin
			word_r <= lock_word;
			pend_r <= 1'b1;
		end else if (push_ok) begin
			pend_r <= 1'b0;
		end
	end

	// Word buffer between the frame engine and the channel registers
	logic          q_in_ready;
	logic          q_out_valid;
	logic [WB-1:0] q_out_data;
	wire           apply_ready = ~load_rise;
	wire           apply_take  = q_out_valid & apply_ready;

	assign push_ok = pend_r & q_in_ready;

	qds_buf2 #(
		.W     (WB),
		.DEPTH (2)
	) u_buf (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (pend_r),
		.in_ready  (q_in_ready),
		.in_data   (word_r),
		.out_valid (q_out_valid),
		.out_ready (apply_ready),
		.out_data  (q_out_data)
	);

	// Channel buffers and output registers
	logic [DB-1:0] buf_r [4];
	logic [DB-1:0] ch_r  [4];
	logic          applied_r;

	wire qds_pkg::qds_mode_t ap_mode = mode_of(q_out_data);
	wire qds_pkg::qds_chan_t ap_chan = chan_of(q_out_data);
	wire [DB-1:0]            ap_data =
	                         q_out_data[`QDS_DATA_HI:`QDS_DATA_LO];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) begin
				buf_r[i] <= `QDS_CH_RST;
				ch_r[i]  <= `QDS_CH_RST;
			end
			applied_r <= 1'b0;
		end else begin
			applied_r <= apply_take;
			if (load_rise) begin
				for (int i = 0; i < 4; i++) begin
					ch_r[i] <= buf_r[i];
				end
			end else if (apply_take) begin
				buf_r[ap_chan] <= ap_data;
				for (int i = 0; i < 4; i++) begin
					if (ap_mode == `QDS_MODE_ALL) begin
						ch_r[i] <= (i == int'(ap_chan)) ? ap_data : buf_r[i];
					end else if (ap_mode == `QDS_MODE_ONE &&
					             i == int'(ap_chan)) begin
						ch_r[i] <= ap_data;
					end
				end
			end
		end
	end

	assign ch0_value     = ch_r[0];
	assign ch1_value     = ch_r[1];
	assign ch2_value     = ch_r[2];
	assign ch3_value     = ch_r[3];
	assign word_applied  = applied_r;
	assign frame_aborted = abort_r;

	// Checks
	sequence locked_ok_s;
		lock && addr_ok;
	endsequence

	sequence applied_s;
		##[1:8] applied_r;
	endsequence

	locked_shreg_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r != qds_pkg::QDS_SHIFT) && sclk_fall |=> $stable(shreg_r))
		else $error("shift register moved outside a frame");

	abort_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == qds_pkg::QDS_SHIFT) && sync_rise |=>
		(state_r == qds_pkg::QDS_IDLE) && (cnt_r == 5'h00) && abort_r)
		else $error("early frame select rise did not abort");

	shift_bit_a: assert property (@(posedge clk) disable iff (!rst_b)
		take_bit |=> (shreg_r[0] == $past(din_bit)) &&
		(cnt_r == $past(cnt_r) + 5'h01))
		else $error("serial bit not shifted in");

	lock_24_a: assert property (@(posedge clk) disable iff (!rst_b)
		take_bit && (cnt_r == 5'd23) |=> state_r == qds_pkg::QDS_LOCK)
		else $error("no lock after the 24th edge");

	enable_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
		port_off |=> state_r != qds_pkg::QDS_SHIFT)
		else $error("frame active while port disabled");

	frame_start_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r != qds_pkg::QDS_SHIFT) ##1 (state_r == qds_pkg::QDS_SHIFT)
		|-> $past(sync_fall) && (cnt_r == 5'h00))
		else $error("frame started without frame select fall");

	addr_match_a: assert property (@(posedge clk) disable iff (!rst_b)
		lock && !addr_ok && !pend_r |=> !pend_r)
		else $error("frame for another address accepted");

	apply_soon_a: assert property (@(posedge clk) disable iff (!rst_b)
		locked_ok_s |-> applied_s)
		else $error("locked word not applied in time");

	load_all_a: assert property (@(posedge clk) disable iff (!rst_b)
		load_rise |=> (ch_r[0] == $past(buf_r[0])) &&
		(ch_r[3] == $past(buf_r[3])))
		else $error("load strobe did not transfer buffers");

	data_field_a: assert property (@(posedge clk) disable iff (!rst_b)
		apply_take && (ap_mode == `QDS_MODE_ONE) && (ap_chan == 2'h1) |=>
		ch_r[1] == $past(q_out_data[15:0]))
		else $error("data field not the low sixteen bits");

	enable_abort_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == qds_pkg::QDS_SHIFT) && port_off |=>
		(state_r == qds_pkg::QDS_IDLE) && abort_r)
		else $error("disable in mid-frame did not abort");

	abort_clean_a: assert property (@(posedge clk) disable iff (!rst_b)
		abort && !pend_r |=> !pend_r)
		else $error("aborted frame queued a word");

	word_queued_a: assert property (@(posedge clk) disable iff (!rst_b)
		locked_ok_s |=> pend_r && (word_r == $past(lock_word)))
		else $error("matching word not queued after lock");

	buf_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		apply_take && (ap_chan == 2'h2) |=> buf_r[2] == $past(ap_data))
		else $error("channel buffer not written");

	outputs_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!load_rise && !apply_take |=> $stable(ch_r[0]) && $stable(ch_r[1]) &&
		$stable(ch_r[2]) && $stable(ch_r[3]))
		else $error("channel output moved without a cause");

endmodule

// ### rtl/qds_regs.svh
`ifndef QDS_REGS_SVH
`define QDS_REGS_SVH

// Serial word layout
`define QDS_WORD_BITS   24
`define QDS_DATA_BITS   16
`define QDS_CNT_BITS    5
`define QDS_LAST_BIT    5'd23
`define QDS_ADDR_HI     23
`define QDS_ADDR_LO     22
`define QDS_MODE_HI     21
`define QDS_MODE_LO     20
`define QDS_CHAN_HI     18
`define QDS_CHAN_LO     17
`define QDS_DATA_HI     15
`define QDS_DATA_LO     0

// Load mode codes
`define QDS_MODE_BUF    2'h0
`define QDS_MODE_ONE    2'h1
`define QDS_MODE_ALL    2'h2

// Synchronised pin vector: bit positions and reset levels
`define QDS_NPINS       7
`define QDS_PIN_SYNC    0
`define QDS_PIN_SCLK    1
`define QDS_PIN_DIN     2
`define QDS_PIN_EN      3
`define QDS_PIN_LOAD    4
`define QDS_PIN_A0      5
`define QDS_PIN_A1      6
`define QDS_PIN_RST     7'h0b

// Reset values
`define QDS_CH_RST      16'h0000
`define QDS_WORD_RST    24'h000000
`define QDS_CNT_RST     5'h00

`endif

// ### rtl/qds_pkg.sv
package qds_pkg;

	typedef enum logic [1:0] {
		QDS_IDLE  = 2'h0,
		QDS_SHIFT = 2'h1,
		QDS_LOCK  = 2'h3
	} qds_frame_t;

	typedef logic [1:0] qds_mode_t;
	typedef logic [1:0] qds_chan_t;

endpackage

// ### rtl/qds_buf2.sv
`timescale 1ns/1ps

module qds_buf2 #(
	parameter int W     = 24,
	parameter int DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_r [DEPTH];
	logic [AW:0]  wr_r;
	logic [AW:0]  rd_r;
	logic [AW:0]  level;
	wire          push;
	wire          pop;

	assign level     = wr_r - rd_r;
	assign in_ready  = (level != DEPTH[AW:0]);
	assign out_valid = (level != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_r[rd_r[AW-1:0]];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r[AW-1:0] == AW'(DEPTH - 1)) ?
				        {~wr_r[AW], {AW{1'b0}}} : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r[AW-1:0] == AW'(DEPTH - 1)) ?
				        {~rd_r[AW], {AW{1'b0}}} : rd_r + 1'b1;
			end
		end
	end

	// Storage needs no reset; valid comes from the pointers
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r[AW-1:0]] <= in_data;
		end
	end

endmodule

// ### dv/qds_host_model.sv
`timescale 1ns/1ps

module qds_host_model (
	output logic frame_select_n,
	output logic serial_clock,
	output logic serial_data_in
);
	initial begin
		frame_select_n = 1'b1;
		serial_clock   = 1'b1;
		serial_data_in = 1'b0;
	end

	// Clock stands high outside frames; data inverts after the last bit, before release
	task automatic send(input logic [23:0] w, input int nbits,
		input bit slow, input bit hold_low);
		realtime h;
		h = slow ? 250.0 : 62.5;
		if (frame_select_n === 1'b0) begin
			frame_select_n = 1'b1;
			#(250);
		end
		frame_select_n = 1'b0;
		#(h);
		for (int i = 0; i < nbits; i++) begin
			serial_data_in = w[23 - (i % 24)];
			#(h) serial_clock = 1'b0;
			#(h) serial_clock = 1'b1;
		end
		serial_data_in = ~serial_data_in;
		#(h);
		if (!hold_low)
			frame_select_n = 1'b1;
		#(250);
	endtask
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps

module tb;
	logic        clk             = 1'b0;
	logic        rst_b           = 1'b0;
	logic        enable_n        = 1'b0;
	logic        addr_pin_0      = 1'b0;
	logic        addr_pin_1      = 1'b0;
	logic        load_all_strobe = 1'b0;
	wire logic   fsel_n;
	wire logic   sclk;
	wire logic   sdin;
	logic [15:0] ch_value [4];
	logic        word_applied;
	logic        frame_aborted;
	logic [15:0] exp_buf [4] = '{default: 16'h0000};
	logic [15:0] exp_out [4] = '{default: 16'h0000};
	int          n_app, n_abt, exp_app, exp_abt;
	int          err_count, total_checks;
	logic [23:0] w;

	always #4 clk = ~clk;

	qds_host_model i_host (
		.frame_select_n (fsel_n),
		.serial_clock   (sclk),
		.serial_data_in (sdin)
	);

	qds_serial_in i_dut (
		.clk             (clk),
		.rst_b           (rst_b),
		.frame_select_n  (fsel_n),
		.serial_clock    (sclk),
		.serial_data_in  (sdin),
		.enable_n        (enable_n),
		.addr_pin_0      (addr_pin_0),
		.addr_pin_1      (addr_pin_1),
		.load_all_strobe (load_all_strobe),
		.ch0_value       (ch_value[0]),
		.ch1_value       (ch_value[1]),
		.ch2_value       (ch_value[2]),
		.ch3_value       (ch_value[3]),
		.word_applied    (word_applied),
		.frame_aborted   (frame_aborted)
	);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			n_app <= 0;
			n_abt <= 0;
		end else begin
			if (word_applied === 1'b1)
				n_app <= n_app + 1;
			if (frame_aborted === 1'b1)
				n_abt <= n_abt + 1;
		end
	end

	function automatic logic [23:0] mkw(input logic [1:0] m, c,
		input logic [15:0] d);
		return {addr_pin_1, addr_pin_0, m, 1'b0, c, 1'b0, d};
	endfunction

	task automatic check(input string nm, input logic [23:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic pins(input logic en, a1, a0, ld);
		@(posedge clk);
		#1;
		enable_n        = en;
		addr_pin_1      = a1;
		addr_pin_0      = a0;
		load_all_strobe = ld;
		repeat (10) @(posedge clk);
	endtask

	task automatic settle();
		repeat (40) @(posedge clk);
		for (int i = 0; i < 4; i++)
			check($sformatf("ch%0d", i), 24'(ch_value[i]), 24'(exp_out[i]));
		check("applied", 24'(n_app), 24'(exp_app));
		check("aborted", 24'(n_abt), 24'(exp_abt));
	endtask

	// Expected effect of one frame on the channel model
	task automatic frame(input logic [23:0] fw, input int nbits,
		input bit slow, input bit hold);
		i_host.send(fw, nbits, slow, hold);
		if (enable_n === 1'b0) begin
			if (nbits < 24)
				exp_abt++;
			else if (fw[23:22] == {addr_pin_1, addr_pin_0}) begin
				exp_app++;
				exp_buf[fw[18:17]] = fw[15:0];
				if (fw[21:20] == 2'h1)
					exp_out[fw[18:17]] = fw[15:0];
				if (fw[21:20] == 2'h2)
					exp_out = exp_buf;
			end
		end
		settle();
	endtask

	task automatic final_report();
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#500000;
		err_count++;
		final_report();
	end

	initial begin
		void'($urandom(21768));
		repeat (20) @(posedge clk);
		#1 rst_b = 1'b1;
		pins(1'b0, 1'($urandom), 1'($urandom), 1'b0);
		settle();
		// Every mode on every channel; slow clock on odd channels, fast clock on even
		for (int i = 0; i < 16; i++)
			frame(mkw(2'(i >> 2), 2'(i), 16'($urandom)), 24, i[0], 1'b0);
		// Random words, some for another address; select kept low on every other frame
		for (int i = 0; i < 10; i++)
			frame(24'($urandom), 24, 1'b0, i[0]);
		// Clocks past the 24th leave the locked word alone
		w = mkw(2'h1, 2'h2, 16'($urandom));
		frame(w, 30, 1'b0, 1'b1);
		frame(mkw(2'h1, 2'h3, 16'h5a5a), 10, 1'b0, 1'b0);
		// Port switched off in mid-frame aborts it
		fork
			i_host.send(mkw(2'h1, 2'h0, 16'h1234), 24, 1'b0, 1'b0);
			begin
				repeat (100) @(posedge clk);
				#1 enable_n = 1'b1;
			end
		join
		exp_abt++;
		settle();
		pins(1'b1, addr_pin_1, addr_pin_0, 1'b0);
		frame(mkw(2'h2, 2'h0, 16'hffff), 24, 1'b0, 1'b0);
		pins(1'b0, ~addr_pin_1, addr_pin_0, 1'b0);
		for (int i = 0; i < 4; i++)
			frame(mkw(2'h0, 2'(i), 16'($urandom)), 24, 1'b0, 1'b0);
		pins(1'b0, addr_pin_1, addr_pin_0, 1'b1);
		exp_out = exp_buf;
		settle();
		pins(1'b0, addr_pin_1, addr_pin_0, 1'b0);
		final_report();
	end
endmodule
